// ---- core/power_state_wake_detector.sv ----
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns
module power_state_wake_detector (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Register port.
	input wire pm_wake_pkg::reg_req_s reg_req,
	output logic [31:0] reg_rdata,
	// PCI cycle decode.
	input wire pm_wake_pkg::pci_cyc_s pci_cyc,
	output logic cyc_accept,
	output logic master_allow,
	// Configuration and pattern load.
	input wire logic [15:0] eeprom_cfg_word,
	input wire logic tx_path_reset,
	input wire pm_wake_pkg::pat_load_s pat_load,
	// Receive stream and link.
	input wire pm_wake_pkg::rx_byte_s rx,
	input wire logic link_up,
	// Open-drain wake pin.
	input wire logic wake_signal_n_i,
	output logic wake_signal_n_o,
	output logic wake_signal_n_oe
);
	import pm_wake_pkg::*;

	typedef enum logic {SYNC_HUNT, ADDR_RUN} remote_phase_e;

	typedef struct packed {
		logic [1:0] level;
		logic wake_en;
		logic io_decode_en;
		logic mem_decode_en;
		logic master_en;
		logic init;
		logic [2:0] wen;
		logic [2:0] wflag;
		logic [47:0] own_mac_addr;
		logic link_ref;
		logic armed;
		logic [31:0] rdata;
		logic wake_drive;
		logic [PAT_DEPTH-1:0][7:0] pat_mem;
		logic [PAT_AW-1:0] pat_wptr;
		logic [PAT_AW-1:0] pptr;
		logic [7:0] skip;
		logic [7:0] take;
		logic [31:0] crc;
		logic [2:0] ff_cnt;
		logic [2:0] mac_byte;
		logic [3:0] mac_rep;
		logic found;
		remote_phase_e phase;
	} state_s;

	state_s s;
	state_s n;

	logic light_sleep_allowed;
	logic partial_down_allowed;
	logic sleeping;
	logic [31:0] crc_seed;
	logic [31:0] crc_next;

	assign light_sleep_allowed = eeprom_cfg_word[EE_LIGHT_BIT];
	assign partial_down_allowed = eeprom_cfg_word[EE_PARTIAL_BIT];
	assign sleeping = (s.level != LVL_FULL);
	assign crc_seed = rx.sof ? RST_CRC : s.crc;

	wake_crc_step #(
		.POLY(CRC_POLY)
	) i_crc (
		.crc_in(crc_seed),
		.data(rx.data),
		.crc_out(crc_next)
	);

	always_comb begin
		logic [PAT_AW-1:0] p;
		logic [7:0] sk;
		logic [7:0] tk;
		logic [31:0] c;
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] ofs;
		logic [7:0] len;
		logic [PAT_AW-1:0] adv;
		logic [2:0] fc;
		logic [2:0] mb;
		logic [3:0] mr;
		logic fnd;
		logic [7:0] mac_sel;
		logic [31:0] expect_crc;
		logic pat_hit;
		logic remote_hit;
		logic link_hit;
		logic [2:0] set;
		logic [2:0] clr;
		logic [1:0] req_lvl;
		logic lvl_ok;
		logic [2:0] new_wen;
		remote_phase_e ph;
		n = s;
		p = rx.sof ? '0 : s.pptr;
		sk = rx.sof ? 8'h00 : s.skip;
		tk = rx.sof ? 8'h00 : s.take;
		c = crc_seed;
		fc = rx.sof ? 3'h0 : s.ff_cnt;
		mb = rx.sof ? 3'h0 : s.mac_byte;
		mr = rx.sof ? 4'h0 : s.mac_rep;
		fnd = rx.sof ? 1'b0 : s.found;
		ph = rx.sof ? SYNC_HUNT : s.phase;
		b0 = s.pat_mem[p];
		b1 = s.pat_mem[p + PAT_AW'(1)];
		b2 = s.pat_mem[p + PAT_AW'(2)];
		ofs = {4'h0, b0[7:4]};
		len = {4'h0, b0[3:0]};
		adv = PAT_AW'(1);
		mac_sel = 8'h00;
		expect_crc = 32'h0;
		pat_hit = 1'b0;
		remote_hit = 1'b0;
		link_hit = 1'b0;
		clr = 3'h0;
		set = 3'h0;
		req_lvl = reg_req.wdata[PM_LEVEL_LSB +: 2];
		lvl_ok = 1'b0;
		new_wen = reg_req.wdata[2:0];
		n.rdata = 32'h0;

		// Extended offset and length come from the bytes that follow.
		if (b0[7:4] == NIB_EXT) begin
			ofs = b1;
			adv = PAT_AW'(2);
		end
		if (b0[3:0] == NIB_EXT) begin
			len = (b0[7:4] == NIB_EXT) ? b2 : b1;
			adv = adv + PAT_AW'(1);
		end

		// Pattern walk: skip, then fold selected bytes into the CRC.
		if (rx.valid) begin
			if (sk != 8'h00) begin
				sk = sk - 8'h01;
			end else if (tk != 8'h00) begin
				c = crc_next;
				tk = tk - 8'h01;
			end else if (b0 != PAT_END) begin
				p = p + adv;
				if (ofs != 8'h00) begin
					sk = ofs - 8'h01;
					tk = len;
				end else if (len != 8'h00) begin
					c = crc_next;
					tk = len - 8'h01;
				end
			end
			expect_crc = {s.pat_mem[p + PAT_AW'(4)], s.pat_mem[p + PAT_AW'(3)],
				s.pat_mem[p + PAT_AW'(2)], s.pat_mem[p + PAT_AW'(1)]};
			// The end byte marks a finished pattern; its CRC follows.
			pat_hit = rx.eof && rx.pass && (s.pat_wptr != '0) && (sk == 8'h00)
				&& (tk == 8'h00) && (s.pat_mem[p] == PAT_END)
				&& (~c == expect_crc);

			// Remote frame search: sync run then repeated station address.
			mac_sel = s.own_mac_addr[(5 - int'(mb)) * 8 +: 8];
			case (ph)
				SYNC_HUNT: begin
					fc = (rx.data == SYNC_BYTE) ? fc + 3'h1 : 3'h0;
					if (fc == SYNC_LEN) begin
						ph = ADDR_RUN;
						mb = 3'h0;
						mr = 4'h0;
					end
				end
				ADDR_RUN: begin
					if (mb == 3'h0 && mr == 4'h0 && rx.data == SYNC_BYTE) begin
						// A longer sync run keeps waiting for the first address byte.
						fc = SYNC_LEN;
					end else if (rx.data == mac_sel) begin
						if (mb == MAC_LAST_BYTE) begin
							mb = 3'h0;
							if (mr == MAC_LAST_REP) begin
								fnd = 1'b1;
								ph = SYNC_HUNT;
								fc = 3'h0;
								mr = 4'h0;
							end else begin
								mr = mr + 4'h1;
							end
						end else begin
							mb = mb + 3'h1;
						end
					end else begin
						ph = SYNC_HUNT;
						fc = (rx.data == SYNC_BYTE) ? 3'h1 : 3'h0;
						mb = 3'h0;
						mr = 4'h0;
					end
				end
				default: begin
					ph = SYNC_HUNT;
					fc = 3'h0;
				end
			endcase
			remote_hit = rx.eof && rx.pass && fnd;

			n.pptr = p;
			n.skip = sk;
			n.take = tk;
			n.crc = c;
			n.ff_cnt = fc;
			n.mac_byte = mb;
			n.mac_rep = mr;
			n.found = fnd;
			n.phase = ph;
		end

		// Pattern store fills from the transmit path load.
		if (tx_path_reset) begin
			n.pat_wptr = '0;
		end else if (pat_load.wr) begin
			n.pat_mem[s.pat_wptr] = pat_load.data;
			n.pat_wptr = s.pat_wptr + PAT_AW'(1);
		end

		// Link compare against the state caught at enable time.
		link_hit = s.armed && s.wen[WEN_LINK] && (link_up != s.link_ref);

		// Register writes.
		if (reg_req.wr) begin
			case (reg_req.addr)
				OFS_PM_CONTROL: begin
					case (req_lvl)
						LVL_LIGHT: lvl_ok = light_sleep_allowed;
						LVL_PARTIAL: lvl_ok = partial_down_allowed;
						default: lvl_ok = 1'b1;
					endcase
					if (lvl_ok) begin
						n.level = req_lvl;
						if (s.level == LVL_HOT_DOWN && req_lvl == LVL_FULL) begin
							n.init = 1'b0;
							n.io_decode_en = 1'b0;
							n.mem_decode_en = 1'b0;
							n.master_en = 1'b0;
						end
						if (s.level != LVL_FULL && req_lvl == LVL_FULL) begin
							n.armed = 1'b0;
						end
					end
					n.wake_en = reg_req.wdata[PM_WAKE_EN_BIT];
				end
				OFS_CFG_CMD: begin
					n.io_decode_en = reg_req.wdata[CMD_IO_BIT];
					n.mem_decode_en = reg_req.wdata[CMD_MEM_BIT];
					n.master_en = reg_req.wdata[CMD_MASTER_BIT];
					n.init = s.init | (|reg_req.wdata[2:0]);
				end
				OFS_WAKE_CTRL: begin
					n.wen = new_wen;
					clr = reg_req.wdata[WFLAG_LSB +: 3];
					if (new_wen[WEN_LINK] && !s.wen[WEN_LINK]) begin
						n.link_ref = link_up;
						n.armed = 1'b1;
					end else if (!new_wen[WEN_LINK]) begin
						n.armed = 1'b0;
					end
				end
				OFS_MAC_LO: n.own_mac_addr[31:0] = reg_req.wdata;
				OFS_MAC_HI: n.own_mac_addr[47:32] = reg_req.wdata[15:0];
				default: ;
			endcase
		end

		// Event flags: a new event wins over a clear in the same cycle.
		set[WEN_PATTERN] = pat_hit && s.wen[WEN_PATTERN] && sleeping;
		set[WEN_REMOTE] = remote_hit && s.wen[WEN_REMOTE] && sleeping;
		set[WEN_LINK] = link_hit;
		n.wflag = (s.wflag & ~clr) | set;
		if (link_hit) begin
			n.armed = 1'b0;
		end

		// Wake pin drive follows sticky flags, only while asleep.
		n.wake_drive = (n.level != LVL_FULL) && n.wake_en && (|n.wflag);

		// Register reads, data in the following cycle.
		if (reg_req.rd) begin
			case (reg_req.addr)
				OFS_PM_CONTROL: begin
					n.rdata[PM_LEVEL_LSB +: 2] = s.level;
					n.rdata[PM_WAKE_EN_BIT] = s.wake_en;
				end
				OFS_CFG_CMD: n.rdata[2:0] = {s.master_en, s.mem_decode_en, s.io_decode_en};
				OFS_WAKE_CTRL: n.rdata = {21'h0, s.wflag, 5'h0, s.wen};
				OFS_MAC_LO: n.rdata = s.own_mac_addr[31:0];
				OFS_MAC_HI: n.rdata = {16'h0, s.own_mac_addr[47:32]};
				OFS_STATUS: begin
					n.rdata[1:0] = s.level;
					n.rdata[ST_ACTIVE_BIT] = s.init && !sleeping;
					n.rdata[ST_LINK_BIT] = link_up;
					n.rdata[ST_PIN_BIT] = wake_signal_n_i;
					n.rdata[ST_DRIVE_BIT] = s.wake_drive;
				end
				default: n.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s <= '0;
			s.level <= RST_LEVEL;
			s.own_mac_addr <= RST_MAC;
			s.crc <= RST_CRC;
		end else begin
			s <= n;
		end
	end

	// PCI cycle acceptance per power level.
	always_comb begin
		cyc_accept = 1'b0;
		if (pci_cyc.valid) begin
			case (pci_cyc.kind)
				CYC_CFG: cyc_accept = 1'b1;
				CYC_IO: cyc_accept = s.io_decode_en && s.level <= LVL_LIGHT;
				CYC_MEM: cyc_accept = s.mem_decode_en && s.level <= LVL_LIGHT;
				default: cyc_accept = 1'b0;
			endcase
		end
	end

	assign master_allow = s.master_en && s.init && !sleeping;
	assign reg_rdata = s.rdata;
	assign wake_signal_n_o = 1'b0;
	assign wake_signal_n_oe = s.wake_drive;

endmodule

module wake_crc_step #(
	parameter logic [31:0] POLY = pm_wake_pkg::CRC_POLY
) (
	// Running value and received byte.
	input wire logic [31:0] crc_in,
	input wire logic [7:0] data,
	// Value after the byte.
	output logic [31:0] crc_out
);
	import pm_wake_pkg::*;

	always_comb begin
		logic [31:0] r;
		r = crc_in ^ {24'h0, data};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ POLY) : (r >> 1);
		end
		crc_out = r;
	end
endmodule

// ---- core/pm_wake_pkg.sv ----
package pm_wake_pkg;

	// Register byte addresses.
	localparam logic [7:0] OFS_PM_CONTROL = 8'h00;
	localparam logic [7:0] OFS_CFG_CMD = 8'h04;
	localparam logic [7:0] OFS_WAKE_CTRL = 8'h08;
	localparam logic [7:0] OFS_MAC_LO = 8'h0C;
	localparam logic [7:0] OFS_MAC_HI = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// Power control fields.
	localparam int PM_LEVEL_LSB = 0;
	localparam int PM_WAKE_EN_BIT = 8;
	localparam logic [1:0] LVL_FULL = 2'h0;
	localparam logic [1:0] LVL_LIGHT = 2'h1;
	localparam logic [1:0] LVL_PARTIAL = 2'h2;
	localparam logic [1:0] LVL_HOT_DOWN = 2'h3;

	// Command fields.
	localparam int CMD_IO_BIT = 0;
	localparam int CMD_MEM_BIT = 1;
	localparam int CMD_MASTER_BIT = 2;

	// Wake control fields: enables low, sticky flags from WFLAG_LSB.
	localparam int WEN_PATTERN = 0;
	localparam int WEN_REMOTE = 1;
	localparam int WEN_LINK = 2;
	localparam int WFLAG_LSB = 8;

	// Status fields.
	localparam int ST_ACTIVE_BIT = 2;
	localparam int ST_LINK_BIT = 3;
	localparam int ST_PIN_BIT = 4;
	localparam int ST_DRIVE_BIT = 5;

	// Serial EEPROM configuration word bits.
	localparam int EE_LIGHT_BIT = 0;
	localparam int EE_PARTIAL_BIT = 1;

	// Reset values.
	localparam logic [1:0] RST_LEVEL = 2'h0;
	localparam logic [47:0] RST_MAC = 48'h0;
	localparam logic [31:0] RST_CRC = 32'hFFFFFFFF;

	// Pattern store and matching constants.
	localparam int PAT_DEPTH = 64;
	localparam int PAT_AW = 6;
	localparam logic [3:0] NIB_EXT = 4'hF;
	localparam logic [7:0] PAT_END = 8'h00;
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [7:0] SYNC_BYTE = 8'hFF;
	localparam logic [2:0] SYNC_LEN = 3'h6;
	localparam logic [2:0] MAC_LAST_BYTE = 3'h5;
	localparam logic [3:0] MAC_LAST_REP = 4'hF;

	// PCI cycle kinds.
	localparam logic [1:0] CYC_CFG = 2'h0;
	localparam logic [1:0] CYC_IO = 2'h1;
	localparam logic [1:0] CYC_MEM = 2'h2;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic valid;
		logic sof;
		logic eof;
		logic pass;
		logic [7:0] data;
	} rx_byte_s;

	typedef struct packed {
		logic valid;
		logic [1:0] kind;
	} pci_cyc_s;

	typedef struct packed {
		logic wr;
		logic [7:0] data;
	} pat_load_s;

endpackage

// ---- sim/power_state_wake_detector_chk.sv ----
`timescale 1ns/1ns
module power_state_wake_detector_chk (
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Register port.
	input wire pm_wake_pkg::reg_req_s reg_req,
	input wire logic [31:0] reg_rdata,
	// PCI cycles.
	input wire pm_wake_pkg::pci_cyc_s pci_cyc,
	input wire logic cyc_accept,
	input wire logic master_allow,
	// Configuration and stream.
	input wire logic [15:0] eeprom_cfg_word,
	input wire logic tx_path_reset,
	input wire pm_wake_pkg::pat_load_s pat_load,
	input wire pm_wake_pkg::rx_byte_s rx,
	input wire logic link_up,
	// Wake pin.
	input wire logic wake_signal_n_i,
	input wire logic wake_signal_n_o,
	input wire logic wake_signal_n_oe
);
	import pm_wake_pkg::*;
	logic [1:0] lvl;
	logic pe;
	logic [1:0] v;
	logic pm_wr;
	assign v = reg_req.wdata[1:0];
	assign pm_wr = reg_req.wr && reg_req.addr == OFS_PM_CONTROL;
	// Shadow of the power level and the wake pin enable.
	always_ff @(posedge clk) begin
		if (srst) begin
			lvl <= LVL_FULL;
			pe <= 1'b0;
		end else if (pm_wr) begin
			pe <= reg_req.wdata[PM_WAKE_EN_BIT];
			if (!(v == LVL_LIGHT && !eeprom_cfg_word[EE_LIGHT_BIT]) &&
				!(v == LVL_PARTIAL && !eeprom_cfg_word[EE_PARTIAL_BIT])) begin
				lvl <= v;
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	cfg_accept_a: assert property (pci_cyc.valid && pci_cyc.kind == CYC_CFG |-> cyc_accept)
		else $error("config cycle not answered");
	io_gate_a: assert property (pci_cyc.valid && pci_cyc.kind != CYC_CFG && lvl[1] |-> !cyc_accept)
		else $error("io or memory cycle answered while powered down");
	wake_lvl0_a: assert property (lvl == LVL_FULL && $past(lvl) == LVL_FULL |-> !wake_signal_n_oe)
		else $error("wake pin driven at level 0");
	pin_gate_a: assert property (!pe && !$past(pe) |-> !wake_signal_n_oe)
		else $error("wake pin driven while disabled");
	pin_low_a: assert property (wake_signal_n_oe |-> wake_signal_n_o == 1'b0)
		else $error("wake pin driven high");
	master_lvl_a: assert property (lvl != LVL_FULL && $past(lvl) != LVL_FULL |-> !master_allow)
		else $error("master allowed outside level 0");
	rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	status_lvl_a: assert property (reg_req.rd && reg_req.addr == OFS_STATUS |=>
		reg_rdata[1:0] == $past(lvl))
		else $error("status level differs");
	reset_quiet_a: assert property ($fell(srst) |-> !wake_signal_n_oe && !master_allow)
		else $error("outputs active after reset");
endmodule
bind power_state_wake_detector power_state_wake_detector_chk i_chk (
	.clk(clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata), .pci_cyc(pci_cyc),
	.cyc_accept(cyc_accept), .master_allow(master_allow), .eeprom_cfg_word(eeprom_cfg_word),
	.tx_path_reset(tx_path_reset), .pat_load(pat_load), .rx(rx), .link_up(link_up),
	.wake_signal_n_i(wake_signal_n_i), .wake_signal_n_o(wake_signal_n_o),
	.wake_signal_n_oe(wake_signal_n_oe)
);

// ---- sim/rx_stream_model.sv ----
`timescale 1ns/1ns
module rx_stream_model (
	// Clock.
	input wire logic clk,
	// Receive stream and link.
	output pm_wake_pkg::rx_byte_s rx,
	output logic link_up
);
	import pm_wake_pkg::*;
	initial begin
		rx = '0;
		link_up = 1'b1;
	end
	// Sends one byte a clock; the filter verdict rides with the last byte.
	task automatic send(input logic [7:0] f[$], input logic pass);
		foreach (f[i]) begin
			@(posedge clk) rx <= '{valid:1'b1, sof:(i == 0), eof:(i == f.size() - 1),
				pass:pass && (i == f.size() - 1), data:f[i]};
		end
		@(posedge clk) rx <= '{valid:1'b0, sof:1'b0, eof:1'b0, pass:1'b0, data:~f[$]};
	endtask
	task automatic set_link(input logic up);
		@(posedge clk) link_up <= up;
	endtask
endmodule

// ---- sim/power_state_wake_detector_tb_top.sv ----
`timescale 1ns/1ns
module power_state_wake_detector_tb_top;
	import pm_wake_pkg::*;
	logic clk = 0;
	logic srst = 1;
	reg_req_s req = '0;
	pci_cyc_s cyc = '0;
	logic [15:0] ee = 16'h0000;
	logic txr = 0;
	pat_load_s pl = '0;
	rx_byte_s rx;
	logic link_up;
	logic [31:0] rdata;
	logic acc, mas, pin_o, pin_oe;
	wire pin = pin_oe ? pin_o : 1'b1;
	int num_errors = 0;
	int n_tests = 0;
	int cyc_n = 0;
	logic [47:0] mac;
	logic [7:0] f[$];
	logic [7:0] g[$];
	initial begin
		forever #50 clk = ~clk;
	end
	power_state_wake_detector i_dut (.clk(clk), .srst(srst), .reg_req(req), .reg_rdata(rdata),
		.pci_cyc(cyc), .cyc_accept(acc), .master_allow(mas), .eeprom_cfg_word(ee),
		.tx_path_reset(txr), .pat_load(pl), .rx(rx), .link_up(link_up),
		.wake_signal_n_i(pin), .wake_signal_n_o(pin_o), .wake_signal_n_oe(pin_oe));
	rx_stream_model i_far (.clk(clk), .rx(rx), .link_up(link_up));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %0h seen %0h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) req <= '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
		@(posedge clk) req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk) req <= '{wr:1'b0, rd:1'b1, addr:a, wdata:32'h0};
		@(posedge clk) req <= '0;
		#1 chk($sformatf("reg %0h", a), e, rdata & m);
	endtask
	task automatic pc(input logic [1:0] k, input logic e);
		@(posedge clk) cyc <= '{valid:1'b1, kind:k};
		@(negedge clk) chk("accept", 32'(e), 32'(acc));
	endtask
	function automatic logic [31:0] crc(input logic [7:0] b[$]);
		logic [31:0] r;
		r = 32'hFFFFFFFF;
		foreach (b[i]) begin
			r = r ^ {24'h0, b[i]};
			for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ 32'hEDB88320 : r >> 1;
		end
		return ~r;
	endfunction
	task automatic load(input logic [31:0] v);
		logic [7:0] p[9];
		p = '{8'hC2, 8'h71, 8'hF4, 8'h10, 8'h00, v[7:0], v[15:8], v[23:16], v[31:24]};
		@(posedge clk) txr <= 1'b1;
		@(posedge clk) txr <= 1'b0;
		foreach (p[i]) @(posedge clk) pl <= '{wr:1'b1, data:p[i]};
		@(posedge clk) pl <= '0;
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			num_errors++;
			wrap_up();
		end
	end
	initial begin
		void'($urandom(92898));
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		pc(CYC_IO, 1'b0);
		pc(CYC_CFG, 1'b1);
		wr(OFS_CFG_CMD, 32'h7);
		pc(CYC_MEM, 1'b1);
		chk("master", 32'h1, 32'(mas));
		wr(OFS_PM_CONTROL, 32'h3);
		wr(OFS_PM_CONTROL, 32'h0);
		pc(CYC_IO, 1'b0);
		wr(OFS_CFG_CMD, 32'h7);
		wr(OFS_PM_CONTROL, 32'h1);
		rd(OFS_STATUS, 32'h3, 32'h0);
		@(posedge clk) ee <= 16'h0003;
		wr(OFS_PM_CONTROL, 32'h102);
		rd(OFS_STATUS, 32'h3, 32'h2);
		pc(CYC_IO, 1'b0);
		repeat (48) f.push_back(8'($urandom));
		g = {f[12], f[13], f[21], f[38], f[39], f[40], f[41]};
		load(crc(g));
		wr(OFS_WAKE_CTRL, 32'h3);
		i_far.send(f, 1'b0);
		rd(OFS_WAKE_CTRL, 32'h700, 32'h0);
		f[13] = ~f[13];
		i_far.send(f, 1'b1);
		rd(OFS_WAKE_CTRL, 32'h700, 32'h0);
		f[13] = ~f[13];
		i_far.send(f, 1'b1);
		rd(OFS_WAKE_CTRL, 32'h700, 32'h100);
		chk("pin", 32'h0, 32'(pin));
		wr(OFS_WAKE_CTRL, 32'h103);
		rd(OFS_WAKE_CTRL, 32'h700, 32'h0);
		g = f;
		mac = {16'($urandom), $urandom};
		mac[40] = 1'b0;
		wr(OFS_MAC_LO, mac[31:0]);
		wr(OFS_MAC_HI, {16'h0, mac[47:32]});
		f = {8'($urandom), 8'h00, 8'h5A};
		repeat (6) f.push_back(8'hFF);
		repeat (16) for (int k = 5; k >= 0; k--) f.push_back(mac[k*8+:8]);
		f.push_back(8'h3C);
		i_far.send(f, 1'b1);
		rd(OFS_WAKE_CTRL, 32'h700, 32'h200);
		wr(OFS_PM_CONTROL, 32'h100);
		@(negedge clk) chk("pin", 32'h1, 32'(pin));
		wr(OFS_WAKE_CTRL, 32'h303);
		i_far.send(g, 1'b1);
		rd(OFS_WAKE_CTRL, 32'h700, 32'h0);
		i_far.send(f, 1'b1);
		rd(OFS_WAKE_CTRL, 32'h700, 32'h0);
		wr(OFS_PM_CONTROL, 32'h103);
		wr(OFS_WAKE_CTRL, 32'h4);
		i_far.set_link(1'b0);
		repeat (2) @(posedge clk);
		rd(OFS_WAKE_CTRL, 32'h700, 32'h400);
		chk("pin", 32'h0, 32'(pin));
		wrap_up();
	end
endmodule
